// ===== logic/lane_error_counter.sv
`timescale 1ns/10ps
module lane_error_counter #(
  parameter int CNT_W = link_status_pkg::CNT_W
) (
  input wire logic clk, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic clear, // One-cycle pulse that zeroes the counts.
  input link_status_pkg::lane_err_t err_pulse, // One-cycle error events.
  input wire logic [CNT_W-1:0] thresh, // Error threshold.
  output link_status_pkg::lane_err_t flags, // Count at or above threshold.
  output logic [2:0][CNT_W-1:0] counts // Current counts.
);

  link_status_pkg::counter_state_t st_r;
  link_status_pkg::counter_state_t st_nxt;
  logic [2:0] ev;

  // Saturating counters; an event in the clear cycle still counts.
  always_comb begin
    st_nxt = st_r;
    ev = err_pulse;
    for (int i = 0; i < 3; i++) begin
      if (clear) begin
        st_nxt.cnt[i] = {CNT_W{1'b0}};
      end
      if (ev[i] && (st_nxt.cnt[i] != {CNT_W{1'b1}})) begin // R10
        st_nxt.cnt[i] = st_nxt.cnt[i] + 1'b1;
      end
    end
    st_nxt.flags.bad_disparity = st_nxt.cnt[2] >= thresh; // R1
    st_nxt.flags.not_in_table = st_nxt.cnt[1] >= thresh; // R2
    st_nxt.flags.unexpected_k = st_nxt.cnt[0] >= thresh; // R3
  end

  // State register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags = st_r.flags;
  assign counts = st_r.cnt;

endmodule // lane_error_counter

// ===== logic/link_status_pkg.sv
package link_status_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_LANES = 8;
  localparam int CNT_W = 8;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [13:0] LANE_STATUS_BASE_IDX = 14'h04b0;
  localparam logic [13:0] LANE1_STATUS_IDX = 14'h04b1;
  localparam logic [13:0] LANE2_STATUS_IDX = 14'h04b2;
  localparam logic [13:0] ERR_THRESH_IDX = 14'h04c0;
  localparam logic [13:0] LINK_CTRL_IDX = 14'h04c1;
  localparam logic [13:0] ERR_COUNT_IDX = 14'h04c2;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int BAD_DISPARITY_BIT = 7;
  localparam int NOT_IN_TABLE_BIT = 6;
  localparam int UNEXPECTED_K_BIT = 5;
  localparam int DESKEW_BIT = 4;
  localparam int INIT_SYNC_BIT = 3;
  localparam int CONFIG_SUM_BIT = 2;
  localparam int FRAME_SYNC_BIT = 1;
  localparam int CODE_GROUP_BIT = 0;
  localparam int SKIP_ILAS_BIT = 0;
  localparam int CNT_CLEAR_BIT = 1;
  localparam int CNT_LANE_LSB = 8;
  localparam logic [7:0] ERR_THRESH_RST = 8'hff;
  localparam logic [7:0] LANE_STATUS_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic deskew_ok;
    logic init_sync_ok;
    logic config_sum_ok;
    logic frame_sync_ok;
    logic code_group_ok;
  } lane_sync_t;

  typedef struct packed {
    logic bad_disparity;
    logic not_in_table;
    logic unexpected_k;
  } lane_err_t;

  typedef struct packed {
    logic [2:0][CNT_W-1:0] cnt;
    lane_err_t flags;
  } counter_state_t;

  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [7:0] thresh;
    logic skip_ilas;
    logic cnt_clear;
    logic [2:0] cnt_lane;
  } slave_state_t;

endpackage

// ===== logic/serial_lane_link_status.sv
// Operation
// [R1] Bit 7 is one when bad disparity count is at or above threshold.
// [R2] Bit 6 is one when not-in-table count is at or above threshold.
// [R3] Bit 5 is one when unexpected control character count reaches threshold.
// [R4] Bit 4 shows interlane deskew achieved, zero when deskew failed.
// [R5] Bit 3 shows initial lane alignment achieved, zero when lost.
// [R6] Bit 2 shows received configuration checksum correct.
// [R7] Bit 1 shows frame sync achieved, zero when lost.
// [R8] Bit 0 shows code group sync achieved, zero when lost.
// [R9] Software ignores bits 4 to 1 while alignment sequence is skipped.
// [R10] Each lane keeps one 8-bit counter per counted error type.
// [R11] Status bits are live, not sticky; writes to them do nothing.
`timescale 1ns/10ps
module serial_lane_link_status #(
  parameter int NUM_LANES = link_status_pkg::NUM_LANES
) (
  input wire logic clk, // System clock, 100 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input link_status_pkg::axil_req_t axi_req, // AXI4-Lite master signals.
  output link_status_pkg::axil_rsp_t axi_rsp, // AXI4-Lite slave signals.
  input link_status_pkg::lane_sync_t [NUM_LANES-1:0] lane_sync, // Per-lane sync levels.
  input link_status_pkg::lane_err_t [NUM_LANES-1:0] lane_err, // Per-lane error pulses.
  output logic skip_lane_alignment_sequence // Link runs without alignment sequence.
);

  // ---------------------------------------------------------------
  // Per-lane error counters
  // ---------------------------------------------------------------
  // Whole slave state lives in one register; its next value is built below.
  link_status_pkg::slave_state_t st_r;
  link_status_pkg::slave_state_t st_nxt;
  link_status_pkg::lane_err_t [NUM_LANES-1:0] err_flags;
  logic [NUM_LANES-1:0][2:0][link_status_pkg::CNT_W-1:0] err_counts;

  // One counter block per lane.
  for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
    lane_error_counter #(
      .CNT_W(link_status_pkg::CNT_W)
    ) u_cnt (
      .clk(clk),
      .rst(rst),
      .clear(st_r.cnt_clear),
      .err_pulse(lane_err[g]),
      .thresh(st_r.thresh),
      .flags(err_flags[g]),
      .counts(err_counts[g])
    );
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Assembles one lane status byte from live inputs and counter flags.
  function automatic logic [7:0] status_byte(input link_status_pkg::lane_err_t f,
                                             input link_status_pkg::lane_sync_t s);
    logic [7:0] b;
    b = link_status_pkg::LANE_STATUS_RST;
    b[link_status_pkg::BAD_DISPARITY_BIT] = f.bad_disparity; // R1
    b[link_status_pkg::NOT_IN_TABLE_BIT] = f.not_in_table; // R2
    b[link_status_pkg::UNEXPECTED_K_BIT] = f.unexpected_k; // R3
    b[link_status_pkg::DESKEW_BIT] = s.deskew_ok; // R4
    b[link_status_pkg::INIT_SYNC_BIT] = s.init_sync_ok; // R5
    b[link_status_pkg::CONFIG_SUM_BIT] = s.config_sum_ok; // R6
    b[link_status_pkg::FRAME_SYNC_BIT] = s.frame_sync_ok; // R7
    b[link_status_pkg::CODE_GROUP_BIT] = s.code_group_ok; // R8
    return b;
  endfunction

  // Tells whether a word index falls on a lane status register.
  function automatic logic is_lane_idx(input logic [13:0] idx);
    return (idx >= link_status_pkg::LANE_STATUS_BASE_IDX) &&
           (idx < link_status_pkg::LANE_STATUS_BASE_IDX + 14'(NUM_LANES));
  endfunction

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  // Tells whether a word index names a register; any other index answers with an error.
  function automatic logic is_mapped_idx(input logic [13:0] idx);
    return is_lane_idx(idx) ||
           (idx == link_status_pkg::ERR_THRESH_IDX) ||
           (idx == link_status_pkg::LINK_CTRL_IDX) ||
           (idx == link_status_pkg::ERR_COUNT_IDX);
  endfunction

  // Turns a byte address into a word index; the two low address bits are ignored.
  function automatic logic [13:0] word_idx(input logic [link_status_pkg::ADDR_W-1:0] a);
    return a[link_status_pkg::ADDR_W-1:2];
  endfunction

  // Builds the control word as read back; the clear bit is a pulse and reads zero.
  function automatic logic [31:0] ctrl_word(input logic skip, input logic [2:0] lane);
    logic [31:0] w;
    w = '0;
    w[link_status_pkg::SKIP_ILAS_BIT] = skip;
    w[link_status_pkg::CNT_LANE_LSB +: 3] = lane;
    return w;
  endfunction

  // Places the three counts of one lane in the low bytes, bad disparity highest.
  function automatic logic [31:0] count_word(
    input logic [2:0][link_status_pkg::CNT_W-1:0] c
  );
    return 32'(c);
  endfunction

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic [13:0] widx;
  logic [13:0] ridx;
  logic [13:0] lane_off;
  logic [2:0] lane_sel;

  // ---------------------------------------------------------------
  // Bus outputs
  // ---------------------------------------------------------------
  // Readies are combinational, so a refusal shows in the cycle of the request.
  assign axi_rsp.awready = !st_r.aw_held && !st_r.bvalid;
  assign axi_rsp.wready = !st_r.w_held && !st_r.bvalid;
  assign axi_rsp.arready = !st_r.rvalid;
  assign axi_rsp.bvalid = st_r.bvalid;
  assign axi_rsp.bresp = st_r.bresp;
  assign axi_rsp.rvalid = st_r.rvalid;
  assign axi_rsp.rdata = st_r.rdata;
  assign axi_rsp.rresp = st_r.rresp;

  // Skip mode leaves the status bits driven; software is expected to ignore them.
  assign skip_lane_alignment_sequence = st_r.skip_ilas;

  // Next-state logic for both channels and the control registers.
  always_comb begin
    // Hold everything by default; the counter clear strobe lasts one cycle only.
    st_nxt = st_r;
    st_nxt.cnt_clear = 1'b0;
    // A channel is taken at the edge where its valid meets its ready.
    aw_take = axi_req.awvalid && axi_rsp.awready;
    w_take = axi_req.wvalid && axi_rsp.wready;
    ar_take = axi_req.arvalid && axi_rsp.arready;
    // Word indices of both addresses and the lane that a status read selects.
    widx = word_idx(st_r.aw_addr);
    ridx = word_idx(axi_req.araddr);
    lane_off = ridx - link_status_pkg::LANE_STATUS_BASE_IDX;
    lane_sel = lane_off[2:0];
    // Address and data are held apart, so the master may offer them in either order.
    if (aw_take) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = axi_req.awaddr;
    end
    if (w_take) begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = axi_req.wdata;
      st_nxt.w_strb = axi_req.wstrb;
    end
    // Write commit once both address and data are held.
    if (st_r.aw_held && st_r.w_held) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = link_status_pkg::RESP_OKAY;
      // A field changes only when the byte strobe that carries it is set.
      if (widx == link_status_pkg::ERR_THRESH_IDX) begin
        if (st_r.w_strb[0]) begin
          st_nxt.thresh = st_r.w_data[7:0];
        end
      end else if (widx == link_status_pkg::LINK_CTRL_IDX) begin
        if (st_r.w_strb[0]) begin
          st_nxt.skip_ilas = st_r.w_data[link_status_pkg::SKIP_ILAS_BIT];
          st_nxt.cnt_clear = st_r.w_data[link_status_pkg::CNT_CLEAR_BIT];
        end
        if (st_r.w_strb[1]) begin
          st_nxt.cnt_lane = st_r.w_data[link_status_pkg::CNT_LANE_LSB +: 3];
        end
      end else if (!is_mapped_idx(widx)) begin
        st_nxt.bresp = link_status_pkg::RESP_SLVERR;
      end
      // Status and count registers are read-only; a write leaves them alone.
    end // R11
    // A write answer drops once the master has taken it; the readies return with it.
    if (st_r.bvalid && axi_req.bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // Read data stand until the master takes them.
    if (st_r.rvalid && axi_req.rready) begin
      st_nxt.rvalid = 1'b0;
    end
    // Read capture: status bits are sampled live, never latched earlier.
    if (ar_take) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = link_status_pkg::RESP_OKAY;
      st_nxt.rdata = '0;
      if (is_lane_idx(ridx) && (32'(lane_sel) < NUM_LANES)) begin
        st_nxt.rdata[7:0] = status_byte(err_flags[lane_sel], lane_sync[lane_sel]); // R11
      end else if (ridx == link_status_pkg::ERR_THRESH_IDX) begin
        st_nxt.rdata[7:0] = st_r.thresh;
      end else if (ridx == link_status_pkg::LINK_CTRL_IDX) begin
        st_nxt.rdata = ctrl_word(st_r.skip_ilas, st_r.cnt_lane);
      end else if (ridx == link_status_pkg::ERR_COUNT_IDX) begin
        if (32'(st_r.cnt_lane) < NUM_LANES) begin
          st_nxt.rdata = count_word(err_counts[st_r.cnt_lane]);
        end
      end else begin
        st_nxt.rresp = link_status_pkg::RESP_SLVERR;
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Reset clears the whole state and then loads the threshold default.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.thresh <= link_status_pkg::ERR_THRESH_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // serial_lane_link_status

// ===== tb/lane_tx_model.sv
`timescale 1ns/10ps
module lane_tx_model #(
  parameter int NUM_LANES = 8
) (
  input wire logic clk, // System clock.
  input wire logic rst, // Reset, active high.
  input link_status_pkg::lane_sync_t [NUM_LANES-1:0] sync_cmd, // Wanted levels.
  input link_status_pkg::lane_err_t [NUM_LANES-1:0] err_cmd, // Wanted events.
  output link_status_pkg::lane_sync_t [NUM_LANES-1:0] lane_sync, // Lane levels.
  output link_status_pkg::lane_err_t [NUM_LANES-1:0] lane_err // One-cycle events.
);
  // Lanes start unsynchronised; each commanded event lasts one cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lane_sync <= '0;
      lane_err <= '0;
    end else begin
      lane_sync <= sync_cmd;
      lane_err <= err_cmd;
    end
  end
endmodule // lane_tx_model

// ===== tb/link_status_assertions.sv
`timescale 1ns/10ps
module link_status_assertions #(
  parameter int NUM_LANES = 8
) (
  input wire logic clk, // System clock.
  input wire logic rst, // Asynchronous reset.
  input link_status_pkg::axil_req_t axi_req, // Bus requests.
  input link_status_pkg::axil_rsp_t axi_rsp, // Bus answers.
  input link_status_pkg::lane_sync_t [NUM_LANES-1:0] lane_sync, // Sync levels.
  input link_status_pkg::lane_err_t [NUM_LANES-1:0] lane_err, // Error pulses.
  input wire logic skip_lane_alignment_sequence // Skip mode.
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Acceptance events on the register bus.
  sequence ar_take;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  sequence wr_take;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  a_read_answer: assert property (ar_take |=> axi_rsp.rvalid)
    else $error("read not answered");
  a_read_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data dropped");
  a_read_block: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read taken while busy");
  a_write_answer: assert property (wr_take |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid)
    else $error("write answer late");
  a_write_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=>
    axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write answer dropped");
  a_lane1_live: assert property (
    ar_take ##0 axi_req.araddr[15:2] == link_status_pkg::LANE1_STATUS_IDX |=>
    axi_rsp.rdata[4:0] == $past(lane_sync[1]) && axi_rsp.rdata[31:8] == 24'h0)
    else $error("lane 1 sync bits wrong");
  a_lane2_live: assert property (
    ar_take ##0 axi_req.araddr[15:2] == link_status_pkg::LANE2_STATUS_IDX |=>
    axi_rsp.rdata[4:0] == $past(lane_sync[2])) else $error("lane 2 sync bits wrong");
  a_ro_write: assert property (
    wr_take ##0 axi_req.awaddr[15:2] == link_status_pkg::LANE1_STATUS_IDX |->
    ##2 axi_rsp.bvalid && axi_rsp.bresp == link_status_pkg::RESP_OKAY)
    else $error("status write refused");
  a_skip_commit: assert property ($changed(skip_lane_alignment_sequence) |->
    $rose(axi_rsp.bvalid)) else $error("skip changed without write");
endmodule // link_status_assertions

bind serial_lane_link_status link_status_assertions #(.NUM_LANES(NUM_LANES)) u_chk (
  .clk(clk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp), .lane_sync(lane_sync),
  .lane_err(lane_err), .skip_lane_alignment_sequence(skip_lane_alignment_sequence));

// ===== tb/serial_lane_link_status_tb_top.sv
`timescale 1ns/10ps
module serial_lane_link_status_tb_top;
  localparam logic [15:0] st_a = {link_status_pkg::LANE_STATUS_BASE_IDX, 2'b00};
  localparam logic [15:0] th_a = {link_status_pkg::ERR_THRESH_IDX, 2'b00};
  localparam logic [15:0] ct_a = {link_status_pkg::LINK_CTRL_IDX, 2'b00};
  localparam logic [15:0] cn_a = {link_status_pkg::ERR_COUNT_IDX, 2'b00};
  logic clk = 1'b0;
  logic rst = 1'b1;
  link_status_pkg::axil_req_t req = '0;
  link_status_pkg::axil_rsp_t rsp;
  link_status_pkg::lane_sync_t [7:0] sc = '0;
  link_status_pkg::lane_sync_t [7:0] ls;
  link_status_pkg::lane_err_t [7:0] ec = '0;
  link_status_pkg::lane_err_t [7:0] le;
  logic skip;
  logic [31:0] d;
  logic [1:0] r;
  int num_errors = 0;
  int checked = 0;
  int th = 255;
  int skm = 0;
  int cnt[8][3] = '{default: '{default: 0}};

  serial_lane_link_status DUT (.clk(clk), .rst(rst), .axi_req(req), .axi_rsp(rsp),
    .lane_sync(ls), .lane_err(le), .skip_lane_alignment_sequence(skip));
  lane_tx_model TX (.clk(clk), .rst(rst), .sync_cmd(sc), .err_cmd(ec), .lane_sync(ls),
    .lane_err(le));

  // Free-running 100 MHz clock.
  initial forever #5 clk = ~clk;

  // Compares one result and counts it.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic test_done;
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Bus master: each channel held until its ready is sampled high.
  // Readiness is sampled at the falling edge, where it has settled before the taking edge.
  task automatic wr(input logic [15:0] a, input logic [31:0] v, output logic [1:0] rr);
    int n;
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    b_ok = 1'b0;
    rr = 2'h0;
    req.awaddr <= a;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (n = 0; n < 99 && !b_ok; n++) begin
      @(negedge clk);
      aw_ok = req.awvalid && rsp.awready;
      w_ok = req.wvalid && rsp.wready;
      b_ok = rsp.bvalid;
      rr = rsp.bresp;
      @(posedge clk);
      if (aw_ok) req.awvalid <= 1'b0;
      if (w_ok) req.wvalid <= 1'b0;
    end
    req.bready <= 1'b0;
    if (!b_ok) begin
      num_errors++;
      test_done();
    end
    @(posedge clk);
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] q, output logic [1:0] rr);
    int n;
    logic ar_ok;
    logic r_ok;
    r_ok = 1'b0;
    q = 32'h0;
    rr = 2'h0;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (n = 0; n < 99 && !r_ok; n++) begin
      @(negedge clk);
      ar_ok = req.arvalid && rsp.arready;
      r_ok = rsp.rvalid;
      q = rsp.rdata;
      rr = rsp.rresp;
      @(posedge clk);
      if (ar_ok) req.arvalid <= 1'b0;
    end
    req.rready <= 1'b0;
    if (!r_ok) begin
      num_errors++;
      test_done();
    end
    @(posedge clk);
  endtask

  // Sends m error events of type k on lane n and tracks the saturating count.
  task automatic inj(input int n, input int k, input int m);
    repeat (m) begin
      ec[n][2-k] <= 1'b1;
      @(posedge clk);
      ec[n][2-k] <= 1'b0;
      @(posedge clk);
      if (cnt[n][k] < 255) cnt[n][k]++;
    end
    repeat (2) @(posedge clk);
  endtask

  // Reads one lane status word; bits 4 to 1 are ignored in skip mode, bit 0 is still checked.
  task automatic cst(input int n);
    logic [31:0] e;
    logic [31:0] m;
    e = {27'h0, sc[n]};
    for (int k = 0; k < 3; k++) e[7-k] = (cnt[n][k] >= th);
    m = (skm != 0) ? 32'hffffffe1 : 32'hffffffff;
    rd(st_a + 16'(4 * n), d, r);
    chk(d & m, e & m);
    chk({30'h0, r}, {30'h0, link_status_pkg::RESP_OKAY});
  endtask

  // Main sequence.
  initial begin
    void'($urandom(32'h7936cad3));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(th_a, d, r);
    chk(d, 32'h000000ff);
    chk({31'h0, skip}, 32'h0);
    for (int n = 0; n < 8; n++) cst(n);
    rd(16'h0000, d, r);
    chk({30'h0, r}, {30'h0, link_status_pkg::RESP_SLVERR});
    wr(16'h0000, 32'h0, r);
    chk({30'h0, r}, {30'h0, link_status_pkg::RESP_SLVERR});
    sc <= 40'({$urandom, $urandom});
    repeat (2) @(posedge clk);
    for (int n = 0; n < 8; n++) cst(n);
    th = $urandom_range(4, 1);
    wr(th_a, 32'(th), r);
    chk({30'h0, r}, {30'h0, link_status_pkg::RESP_OKAY});
    for (int n = 1; n < 3; n++) begin
      for (int k = 0; k < 3; k++) begin
        inj(n, k, th - 1);
        cst(n);
        inj(n, k, 1);
        cst(n);
      end
    end
    wr(st_a + 16'h0004, 32'h000000ff, r);
    chk({30'h0, r}, {30'h0, link_status_pkg::RESP_OKAY});
    cst(1);
    wr(ct_a, 32'h00000001, r);
    skm = 1;
    chk({31'h0, skip}, 32'h1);
    cst(1);
    wr(ct_a, 32'h00000003, r);
    cnt = '{default: '{default: 0}};
    repeat (2) @(posedge clk);
    cst(1);
    cst(2);
    th = 255;
    wr(th_a, 32'h000000ff, r);
    inj(2, 0, 260);
    cst(2);
    wr(ct_a, 32'h00000201, r);
    rd(ct_a, d, r);
    chk(d, 32'h00000201);
    rd(cn_a, d, r);
    chk(d, {8'h0, 8'(cnt[2][0]), 8'(cnt[2][1]), 8'(cnt[2][2])});
    test_done();
  end
endmodule // serial_lane_link_status_tb_top
